// ==== rtl/lcer_pkg.sv ====
`default_nettype none

package lcer_pkg;

   // ----------------------------------------
   // bus geometry
   // ----------------------------------------
   localparam int unsigned LCER_ADDR_W = 8;
   localparam int unsigned LCER_DATA_W = 16;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] LCER_OFF_RATE_MASK = 8'h0a;
   localparam logic [7:0] LCER_OFF_FEATURES = 8'h0c;
   localparam logic [7:0] LCER_OFF_SCRATCH = 8'h10;
   localparam logic [7:0] LCER_OFF_LINK_ERR = 8'h11;
   localparam logic [7:0] LCER_OFF_ERR_ROUTE = 8'h12;

   // ----------------------------------------
   // feature flag positions and widths
   // ----------------------------------------
   localparam int unsigned LCER_FEAT_HOST_W = 16;
   localparam int unsigned LCER_FEAT_DEV_W = 8;
   localparam int unsigned LCER_FEAT_ISOC = 0;
   localparam int unsigned LCER_FEAT_STOP = 1;
   localparam int unsigned LCER_FEAT_CRC_TEST = 2;
   localparam int unsigned LCER_FEAT_LONG_CTL = 3;
   localparam int unsigned LCER_FEAT_ADDR64 = 4;
   localparam int unsigned LCER_FEAT_UNIT_ORDER = 5;
   localparam int unsigned LCER_FEAT_SRC_TAG = 6;
   localparam int unsigned LCER_FEAT_EXT_REGS = 8;
   localparam int unsigned LCER_FEAT_UPCFG = 9;

   // ----------------------------------------
   // rate mask positions
   // ----------------------------------------
   localparam int unsigned LCER_RATE_BASE = 0;
   localparam int unsigned LCER_RATE_VENDOR = 15;

   // ----------------------------------------
   // error routing and link error positions
   // ----------------------------------------
   localparam int unsigned LCER_ER_PROT_FLOOD = 0;
   localparam int unsigned LCER_ER_OVF_FLOOD = 1;
   localparam int unsigned LCER_ER_PROT_FATAL = 2;
   localparam int unsigned LCER_ER_CHAIN_FAIL = 8;
   localparam int unsigned LCER_LE_PROT = 4;
   localparam int unsigned LCER_LE_OVF = 5;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [15:0] LCER_SCRATCH_RST = 16'h0000;
   localparam logic [15:0] LCER_ZERO16 = 16'h0000;
   localparam logic LCER_UPCFG_RST = 1'b1;
   localparam logic LCER_WARM_BIT_RST = 1'b0;

   // ----------------------------------------
   // modes and states
   // ----------------------------------------
   typedef enum logic [1:0] {
      LCER_ORDER_RW = 2'h0,
      LCER_ORDER_FIXED = 2'h1,
      LCER_ORDER_LEGACY = 2'h2
   } lcer_order_mode_t;

   typedef enum logic [1:0] {
      LCER_FL_IDLE = 2'b01,
      LCER_FL_FLOOD = 2'b10
   } lcer_flood_state_t;

endpackage : lcer_pkg

`default_nettype wire

// ==== rtl/lcer_evt_if.sv ====
`default_nettype none

interface lcer_evt_if;
   // one-cycle pulses on ref_clk, one per link clock rising edge that saw the error
   logic prot_evt;
   logic ovf_evt;

   modport src (output prot_evt, output ovf_evt);
   modport dst (input prot_evt, input ovf_evt);
endinterface : lcer_evt_if

`default_nettype wire

// ==== rtl/lcer_link_sampler.sv ====
`default_nettype none

module lcer_link_sampler (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic link_clk,
   input wire logic link_prot_err,
   input wire logic link_ovf_err,
   lcer_evt_if.src evt
);

   // ----------------------------------------
   // two-flop synchronisers
   // ----------------------------------------
   // the first stage feeds only the second; edges are found one stage later
   logic [2:0] meta_q, meta_d;
   logic [2:0] sync_q, sync_d;
   logic clk_dly_q, clk_dly_d;
   logic prot_evt_q, prot_evt_d;
   logic ovf_evt_q, ovf_evt_d;
   logic rise;

   always_comb begin
      meta_d = {link_ovf_err, link_prot_err, link_clk};
      sync_d = meta_q;
      clk_dly_d = sync_q[0];
      rise = sync_q[0] & ~clk_dly_q;
      // errors are taken at the link clock rising edge, same latency as the clock path
      prot_evt_d = rise & sync_q[1];
      ovf_evt_d = rise & sync_q[2];
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meta_q <= 3'h0;
         sync_q <= 3'h0;
         clk_dly_q <= 1'b0;
         prot_evt_q <= 1'b0;
         ovf_evt_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         clk_dly_q <= clk_dly_d;
         prot_evt_q <= prot_evt_d;
         ovf_evt_q <= ovf_evt_d;
      end
   end

   assign evt.prot_evt = prot_evt_q;
   assign evt.ovf_evt = ovf_evt_q;

endmodule : lcer_link_sampler

`default_nettype wire

// ==== rtl/lcer_regs.sv ====
// Function
// - rate support mask is 16 read-only bits, bit N means rate code N supported.
// - rate mask bit 0 always reads 1, base rate is mandatory.
// - rate mask bit 15 set means vendor-defined rates are available.
// - feature register is 16 bits in hosts, 8 bits elsewhere, undefined bits reserved.
// - feature bit 0 read-only, isochronous flow control capable.
// - feature bit 1 read-only, link stop and disconnect supported.
// - feature bit 2 read-only, CRC testing mode supported.
// - feature bit 3 read-only, long control lane hold needed; peer must honour it.
// - feature bit 4 read-only, address extension doublewords accepted and forwarded.
// - feature bit 5 read-write, warm reset clears, keeps unit identifiers ordered together.
// - fixed-order devices hardwire bit 5 to 1; legacy devices read it as 0.
// - feature bit 6 read-only, source tag extension received and forwarded.
// - feature bit 8 read-only in hosts shows extended registers exist.
// - feature bit 9 read-write, warm reset sets; clear rejects upstream config requests.
// - enumeration scratch is read-write, cleared by cold reset.
// - unchecked error conditions hardwire their log and routing bits to 0.
// - routing bit 0 floods link on logged protocol error, slaves also need system error enable.
// - routing bit 1 floods link on logged overflow error, same enable condition.
// - secondary chain reset does not clear flood enables.
// - routing bit 2 raises fatal interrupt on logged protocol error; absent interrupt hardwires 0.
// - protocol and overflow logs set on detection, cleared by read and cold reset.
// - chain fail sets on flooding or flood error; only chain reset clears it. Here warm reset clears it too.
//
// The address-and-strobe port was decided locally.
`default_nettype none

module lcer_regs
   import lcer_pkg::*;
#(
   parameter bit IS_HOST = 1'b0,
   parameter bit IS_SLAVE = 1'b1,
   parameter logic [15:0] RATE_MASK = 16'h0001,
   parameter bit CAP_ISOC = 1'b0,
   parameter bit CAP_STOP = 1'b0,
   parameter bit CAP_CRC_TEST = 1'b0,
   parameter bit CAP_LONG_CTL = 1'b0,
   parameter bit CAP_ADDR64 = 1'b0,
   parameter bit CAP_SRC_TAG = 1'b0,
   parameter bit HOST_EXT_REGS = 1'b1,
   parameter bit HOST_UPCFG_ZERO = 1'b0,
   parameter lcer_order_mode_t ORDER_MODE = LCER_ORDER_RW,
   parameter bit CHECKS_PROT = 1'b1,
   parameter bit CHECKS_OVF = 1'b1,
   parameter bit HAS_FATAL_IRQ = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic warm_rst,
   input wire logic chain_rst,
   input wire logic sys_err_en,
   input wire logic link_clk,
   input wire logic link_prot_err,
   input wire logic link_ovf_err,
   input wire logic [LCER_ADDR_W-1:0] reg_addr,
   input wire logic [LCER_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [LCER_DATA_W-1:0] reg_rdata_q,
   input wire logic upstream_cfg_req,
   output logic upstream_cfg_reject_q,
   output logic unit_order_together_q,
   output logic sync_flood_q,
   output logic fatal_err_irq_q,
   output logic chain_fail_q
);

   // ----------------------------------------
   // structural constants
   // ----------------------------------------
   // extended registers always exist outside hosts
   localparam bit EXT_PRESENT = !IS_HOST || HOST_EXT_REGS;
   localparam bit UPCFG_RW = IS_HOST && !HOST_UPCFG_ZERO;
   localparam int unsigned FEAT_W = IS_HOST ? LCER_FEAT_HOST_W : LCER_FEAT_DEV_W;
   localparam bit PROT_OK = CHECKS_PROT;
   localparam bit OVF_OK = CHECKS_OVF;
   localparam bit FATAL_OK = CHECKS_PROT && HAS_FATAL_IRQ;
   // without a fatal interrupt line the fatal enable is tied low and reads as zero

   // ----------------------------------------
   // link error events
   // ----------------------------------------
   lcer_evt_if evt ();

   lcer_link_sampler u_sampler (
      .ref_clk(ref_clk),
      .rst(rst),
      .link_clk(link_clk),
      .link_prot_err(link_prot_err),
      .link_ovf_err(link_ovf_err),
      .evt(evt.src)
   );

   // ----------------------------------------
   // access decode
   // ----------------------------------------
   logic wr_feat, wr_scratch, wr_route, rd_link_err;
   // writes to offsets a host has not built are dropped, reads of them return zero

   always_comb begin
      wr_feat = reg_wr && (reg_addr == LCER_OFF_FEATURES);
      wr_scratch = reg_wr && (reg_addr == LCER_OFF_SCRATCH) && EXT_PRESENT;
      wr_route = reg_wr && (reg_addr == LCER_OFF_ERR_ROUTE) && EXT_PRESENT;
      rd_link_err = reg_rd && (reg_addr == LCER_OFF_LINK_ERR);
   end

   // ----------------------------------------
   // warm-reset control bits
   // ----------------------------------------
   // chain_rst is deliberately absent here, so flooding can come back after it
   logic order_q, order_d;
   logic upcfg_q, upcfg_d;
   logic prot_flood_q, prot_flood_d;
   logic ovf_flood_q, ovf_flood_d;
   logic prot_fatal_q, prot_fatal_d;

   always_comb begin
      order_d = order_q;
      upcfg_d = upcfg_q;
      prot_flood_d = prot_flood_q;
      ovf_flood_d = ovf_flood_q;
      prot_fatal_d = prot_fatal_q;
      if (warm_rst) begin
         order_d = LCER_WARM_BIT_RST;
         upcfg_d = LCER_UPCFG_RST;
         prot_flood_d = LCER_WARM_BIT_RST;
         ovf_flood_d = LCER_WARM_BIT_RST;
         prot_fatal_d = LCER_WARM_BIT_RST;
      end else begin
         if (wr_feat) begin
            // read-only capability bits take no part in a write
            order_d = reg_wdata[LCER_FEAT_UNIT_ORDER];
            upcfg_d = reg_wdata[LCER_FEAT_UPCFG];
         end
         if (wr_route) begin
            prot_flood_d = reg_wdata[LCER_ER_PROT_FLOOD];
            ovf_flood_d = reg_wdata[LCER_ER_OVF_FLOOD];
            prot_fatal_d = reg_wdata[LCER_ER_PROT_FATAL];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         order_q <= LCER_WARM_BIT_RST;
         upcfg_q <= LCER_UPCFG_RST;
         prot_flood_q <= LCER_WARM_BIT_RST;
         ovf_flood_q <= LCER_WARM_BIT_RST;
         prot_fatal_q <= LCER_WARM_BIT_RST;
      end else begin
         order_q <= order_d;
         upcfg_q <= upcfg_d;
         prot_flood_q <= prot_flood_d;
         ovf_flood_q <= ovf_flood_d;
         prot_fatal_q <= prot_fatal_d;
      end
   end

   // ----------------------------------------
   // effective bit values
   // ----------------------------------------
   logic order_eff, upcfg_eff, prot_flood_eff, ovf_flood_eff, prot_fatal_eff;
   // hardwired bits read back as zero, except bit 5 in fixed-order mode reads 1, so software sees what the logic really does

   always_comb begin
      unique case (ORDER_MODE)
         LCER_ORDER_RW: order_eff = order_q;
         LCER_ORDER_FIXED: order_eff = 1'b1;
         LCER_ORDER_LEGACY: order_eff = 1'b0;
         default: order_eff = 1'b0;
      endcase
      // non-host devices have no enable bit and always serve upstream config
      upcfg_eff = IS_HOST ? (UPCFG_RW && upcfg_q) : 1'b1;
      prot_flood_eff = PROT_OK && EXT_PRESENT && prot_flood_q;
      ovf_flood_eff = OVF_OK && EXT_PRESENT && ovf_flood_q;
      prot_fatal_eff = FATAL_OK && EXT_PRESENT && prot_fatal_q;
   end

   // ----------------------------------------
   // cold-reset storage: scratch and logs
   // ----------------------------------------
   logic [15:0] scratch_q, scratch_d;
   logic prot_log_q, prot_log_d;
   logic ovf_log_q, ovf_log_d;
   // warm reset leaves scratch and both logs alone, software must read to clear

   always_comb begin
      scratch_d = scratch_q;
      if (wr_scratch) begin
         scratch_d = reg_wdata;
      end
      // a detection in the cycle of the clearing read wins over the clear
      prot_log_d = prot_log_q;
      if (rd_link_err) begin
         prot_log_d = 1'b0;
      end
      if (evt.prot_evt && PROT_OK) begin
         prot_log_d = 1'b1;
      end
      ovf_log_d = ovf_log_q;
      if (rd_link_err) begin
         ovf_log_d = 1'b0;
      end
      if (evt.ovf_evt && OVF_OK) begin
         ovf_log_d = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         scratch_q <= LCER_SCRATCH_RST;
         prot_log_q <= 1'b0;
         ovf_log_q <= 1'b0;
      end else begin
         scratch_q <= scratch_d;
         prot_log_q <= prot_log_d;
         ovf_log_q <= ovf_log_d;
      end
   end

   // ----------------------------------------
   // sync flood and chain fail
   // ----------------------------------------
   // once flooding starts it lasts until a chain reset or a warm reset
   lcer_flood_state_t fl_q, fl_d;
   logic flood_err, flood_gate;
   logic chain_fail_d, flood_d;
   // a chain reset beats a flood error in the same cycle; the error re-arms one cycle later

   always_comb begin
      flood_gate = IS_SLAVE ? sys_err_en : 1'b1;
      flood_err = flood_gate && ((prot_flood_eff && prot_log_q) || (ovf_flood_eff && ovf_log_q));
      fl_d = fl_q;
      unique case (fl_q)
         LCER_FL_IDLE: begin
            if (flood_err && !chain_rst && !warm_rst) begin
               fl_d = LCER_FL_FLOOD;
            end
         end
         LCER_FL_FLOOD: begin
            if (chain_rst || warm_rst) begin
               fl_d = LCER_FL_IDLE;
            end
         end
         default: fl_d = LCER_FL_IDLE;
      endcase
      flood_d = (fl_d == LCER_FL_FLOOD);
      chain_fail_d = chain_fail_q;
      if (chain_rst || warm_rst) begin
         chain_fail_d = 1'b0;
      end else if (flood_err || fl_q == LCER_FL_FLOOD) begin
         chain_fail_d = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fl_q <= LCER_FL_IDLE;
         sync_flood_q <= 1'b0;
         chain_fail_q <= 1'b0;
      end else begin
         fl_q <= fl_d;
         sync_flood_q <= flood_d;
         chain_fail_q <= chain_fail_d;
      end
   end

   // ----------------------------------------
   // side outputs
   // ----------------------------------------
   logic fatal_d, reject_d;
   // fatal follows the log's next value, so it rises together with the log

   always_comb begin
      fatal_d = prot_fatal_eff && prot_log_d;
      reject_d = upstream_cfg_req && !upcfg_eff;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fatal_err_irq_q <= 1'b0;
         upstream_cfg_reject_q <= 1'b0;
         unit_order_together_q <= 1'b0;
      end else begin
         fatal_err_irq_q <= fatal_d;
         upstream_cfg_reject_q <= reject_d;
         unit_order_together_q <= order_eff;
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   logic [15:0] rate_val, feat_val, route_val, lerr_val, rdata_d;
   // bit 0 of the rate mask is forced, so a bad parameter cannot hide the base rate
   // the link error byte is returned as a whole word; only bits 5 and 4 are live

   always_comb begin
      rate_val = RATE_MASK;
      rate_val[LCER_RATE_BASE] = 1'b1;
      feat_val = LCER_ZERO16;
      feat_val[LCER_FEAT_ISOC] = CAP_ISOC;
      feat_val[LCER_FEAT_STOP] = CAP_STOP;
      feat_val[LCER_FEAT_CRC_TEST] = CAP_CRC_TEST;
      feat_val[LCER_FEAT_LONG_CTL] = CAP_LONG_CTL;
      feat_val[LCER_FEAT_ADDR64] = CAP_ADDR64;
      feat_val[LCER_FEAT_UNIT_ORDER] = order_eff;
      feat_val[LCER_FEAT_SRC_TAG] = CAP_SRC_TAG;
      if (FEAT_W > LCER_FEAT_DEV_W) begin
         feat_val[LCER_FEAT_EXT_REGS] = HOST_EXT_REGS;
         feat_val[LCER_FEAT_UPCFG] = UPCFG_RW && upcfg_q;
      end
      route_val = LCER_ZERO16;
      route_val[LCER_ER_PROT_FLOOD] = prot_flood_eff;
      route_val[LCER_ER_OVF_FLOOD] = ovf_flood_eff;
      route_val[LCER_ER_PROT_FATAL] = prot_fatal_eff;
      route_val[LCER_ER_CHAIN_FAIL] = chain_fail_q;
      lerr_val = LCER_ZERO16;
      lerr_val[LCER_LE_PROT] = prot_log_q;
      lerr_val[LCER_LE_OVF] = ovf_log_q;
      rdata_d = LCER_ZERO16;
      if (reg_rd) begin
         unique case (reg_addr)
            LCER_OFF_RATE_MASK: rdata_d = rate_val;
            LCER_OFF_FEATURES: rdata_d = feat_val;
            LCER_OFF_SCRATCH: rdata_d = EXT_PRESENT ? scratch_q : LCER_ZERO16;
            LCER_OFF_LINK_ERR: rdata_d = lerr_val;
            LCER_OFF_ERR_ROUTE: rdata_d = EXT_PRESENT ? route_val : LCER_ZERO16;
            // unmapped offsets read as zero
            default: rdata_d = LCER_ZERO16;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata_q <= LCER_ZERO16;
      end else begin
         reg_rdata_q <= rdata_d;
      end
   end

endmodule : lcer_regs

`default_nettype wire

// ==== sim/lcer_regs_asserts.sv ====
`default_nettype none

module lcer_regs_chk
   import lcer_pkg::*;
#(
   parameter logic [15:0] RATE_MASK = 16'h0001,
   parameter bit IS_SLAVE = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic warm_rst,
   input wire logic chain_rst,
   input wire logic sys_err_en,
   input wire logic link_clk,
   input wire logic link_prot_err,
   input wire logic link_ovf_err,
   input wire logic [LCER_ADDR_W-1:0] reg_addr,
   input wire logic [LCER_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [LCER_DATA_W-1:0] reg_rdata_q,
   input wire logic upstream_cfg_req,
   input wire logic upstream_cfg_reject_q,
   input wire logic unit_order_together_q,
   input wire logic sync_flood_q,
   input wire logic fatal_err_irq_q,
   input wire logic chain_fail_q
);
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------
   // port relations
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_rdata_quiet: assert property (reg_rdata_q != LCER_ZERO16 |-> $past(reg_rd))
      else $error("read data outside its slot");
   a_rate_value: assert property (reg_rd && reg_addr == LCER_OFF_RATE_MASK |=>
      reg_rdata_q == (RATE_MASK | 16'h0001)) else $error("rate mask read wrong");
   a_reject_cause: assert property (upstream_cfg_reject_q |-> $past(upstream_cfg_req))
      else $error("reject without request");
   a_chain_clear: assert property (chain_rst |=> !chain_fail_q && !sync_flood_q)
      else $error("chain reset left flood state");
   a_warm_clear: assert property (warm_rst [*3] |=> !sync_flood_q && !unit_order_together_q && !chain_fail_q)
      else $error("warm reset left state");
   a_flood_gate: assert property ($rose(sync_flood_q) |-> !IS_SLAVE || sys_err_en || $past(sys_err_en))
      else $error("flood without system error enable");
   a_flood_chain: assert property (sync_flood_q |-> chain_fail_q)
      else $error("flood without chain fail");
   a_fatal_drop: assert property (fatal_err_irq_q && reg_wr && reg_addr == LCER_OFF_ERR_ROUTE
      && !reg_wdata[LCER_ER_PROT_FATAL] |-> ##[1:2] !fatal_err_irq_q) else $error("fatal stays after disable");
   a_order_set: assert property (reg_wr && reg_addr == LCER_OFF_FEATURES && !warm_rst
      && reg_wdata[LCER_FEAT_UNIT_ORDER] |-> ##[1:2] unit_order_together_q) else $error("order bit not set");

   c_flood: cover property ($rose(sync_flood_q));
   c_reject: cover property (upstream_cfg_reject_q);
   c_fatal: cover property ($rose(fatal_err_irq_q));
endmodule : lcer_regs_chk

bind lcer_regs lcer_regs_chk #(.RATE_MASK(RATE_MASK), .IS_SLAVE(IS_SLAVE)) u_lcer_regs_chk (
   .ref_clk(ref_clk), .rst(rst), .warm_rst(warm_rst), .chain_rst(chain_rst), .sys_err_en(sys_err_en),
   .link_clk(link_clk), .link_prot_err(link_prot_err), .link_ovf_err(link_ovf_err),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
   .upstream_cfg_req(upstream_cfg_req), .upstream_cfg_reject_q(upstream_cfg_reject_q),
   .unit_order_together_q(unit_order_together_q), .sync_flood_q(sync_flood_q),
   .fatal_err_irq_q(fatal_err_irq_q), .chain_fail_q(chain_fail_q)
);

`default_nettype wire

// ==== sim/lcer_peer.sv ====
`default_nettype none

module lcer_peer (
   output logic link_clk,
   output logic link_prot_err,
   output logic link_ovf_err
);
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------
   // peer link node
   // ----------------------------------------
   initial begin
      link_clk = 1'b0;
      link_prot_err = 1'b0;
      link_ovf_err = 1'b0;
   end

   // one 80 ns link clock period per report; clock stands still between reports
   task automatic burst(input logic p, input logic o);
      #13;
      link_prot_err = p;
      link_ovf_err = o;
      #40 link_clk = 1'b1;
      #40 link_clk = 1'b0;
      link_prot_err = 1'b0;
      link_ovf_err = 1'b0;
      #40;
   endtask : burst
endmodule : lcer_peer

`default_nettype wire

// ==== sim/tb_top.sv ====
`default_nettype none

module tb_top
   import lcer_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic warm_rst = 1'b0;
   logic chain_rst = 1'b0;
   logic sys_err_en = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic upstream_cfg_req = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic [15:0] reg_rdata_q;
   logic link_clk, link_prot_err, link_ovf_err;
   logic upstream_cfg_reject_q, unit_order_together_q, sync_flood_q, fatal_err_irq_q, chain_fail_q;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;

   always #4 ref_clk = ~ref_clk;

   lcer_regs #(.IS_HOST(1'b1), .RATE_MASK(16'h8024), .CAP_STOP(1'b1), .CAP_ADDR64(1'b1)) u_lcer_regs (
      .ref_clk(ref_clk), .rst(rst), .warm_rst(warm_rst), .chain_rst(chain_rst), .sys_err_en(sys_err_en),
      .link_clk(link_clk), .link_prot_err(link_prot_err), .link_ovf_err(link_ovf_err),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
      .upstream_cfg_req(upstream_cfg_req), .upstream_cfg_reject_q(upstream_cfg_reject_q),
      .unit_order_together_q(unit_order_together_q), .sync_flood_q(sync_flood_q),
      .fatal_err_irq_q(fatal_err_irq_q), .chain_fail_q(chain_fail_q));

   lcer_peer u_lcer_peer (.link_clk(link_clk), .link_prot_err(link_prot_err), .link_ovf_err(link_ovf_err));

   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string msg, input logic [15:0] m = 16'hffff);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata_q & m, exp, msg);
   endtask : rd

   task automatic cfg_req(input logic exp);
      @(posedge ref_clk);
      upstream_cfg_req <= 1'b1;
      @(posedge ref_clk);
      upstream_cfg_req <= 1'b0;
      #1 chk({15'h0000, upstream_cfg_reject_q}, {15'h0000, exp}, "reject pulse");
   endtask : cfg_req

   task automatic done_t(input string name);
      $display("test %s done", name);
   endtask : done_t

   task automatic close_out();
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out

   // a hang is cut short well beyond the fewer than two hundred cycles the tests need
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         close_out();
      end
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      rd(LCER_OFF_RATE_MASK, 16'h8025, "rate mask");
      rd(LCER_OFF_FEATURES, 16'h0312, "features");
      rd(LCER_OFF_SCRATCH, 16'h0000, "scratch");
      rd(LCER_OFF_ERR_ROUTE, 16'h0000, "routing");
      rd(LCER_OFF_LINK_ERR, 16'h0000, "logs");
      rd(8'h20, 16'h0000, "unmapped");
      done_t("reset values");

      wr(LCER_OFF_RATE_MASK, 16'hffff);
      rd(LCER_OFF_RATE_MASK, 16'h8025, "rate after write");
      wr(LCER_OFF_FEATURES, 16'hffff);
      rd(LCER_OFF_FEATURES, 16'h0332, "features after write");
      chk({15'h0000, unit_order_together_q}, 16'h0001, "order together");
      wr(LCER_OFF_SCRATCH, 16'ha5c3);
      rd(LCER_OFF_SCRATCH, 16'ha5c3, "scratch rw");
      wr(LCER_OFF_FEATURES, 16'h0000);
      rd(LCER_OFF_FEATURES, 16'h0112, "features cleared");
      cfg_req(1'b1);
      wr(LCER_OFF_FEATURES, 16'h0200);
      cfg_req(1'b0);
      done_t("access kinds");

      wr(LCER_OFF_ERR_ROUTE, 16'h0007);
      wr(LCER_OFF_FEATURES, 16'h0020);
      @(posedge ref_clk);
      warm_rst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      warm_rst <= 1'b0;
      rd(LCER_OFF_FEATURES, 16'h0312, "features after warm");
      rd(LCER_OFF_ERR_ROUTE, 16'h0000, "routing after warm");
      rd(LCER_OFF_SCRATCH, 16'ha5c3, "scratch kept");
      done_t("warm reset");

      // slave without system error enable: fatal only, no flood
      wr(LCER_OFF_ERR_ROUTE, 16'h0005);
      u_lcer_peer.burst(1'b1, 1'b0);
      repeat (8) @(posedge ref_clk);
      chk({15'h0000, sync_flood_q}, 16'h0000, "flood gated");
      chk({15'h0000, fatal_err_irq_q}, 16'h0001, "fatal raised");
      wr(LCER_OFF_ERR_ROUTE, 16'h0000);
      repeat (2) @(posedge ref_clk);
      chk({15'h0000, fatal_err_irq_q}, 16'h0000, "fatal dropped");
      rd(LCER_OFF_LINK_ERR, 16'h0010, "prot log");
      rd(LCER_OFF_LINK_ERR, 16'h0000, "log read clears");
      done_t("protocol error");

      @(posedge ref_clk);
      sys_err_en <= 1'b1;
      wr(LCER_OFF_ERR_ROUTE, 16'h0002);
      u_lcer_peer.burst(1'b0, 1'b1);
      for (int i = 0; i < 30 && sync_flood_q !== 1'b1; i++) @(posedge ref_clk);
      chk({15'h0000, sync_flood_q}, 16'h0001, "overflow flood");
      chk({15'h0000, chain_fail_q}, 16'h0001, "chain fail");
      rd(LCER_OFF_ERR_ROUTE, 16'h0102, "chain fail bit");
      @(posedge ref_clk);
      chain_rst <= 1'b1;
      @(posedge ref_clk);
      chain_rst <= 1'b0;
      rd(LCER_OFF_ERR_ROUTE, 16'h0102, "enables kept");
      rd(LCER_OFF_LINK_ERR, 16'h0020, "ovf log");
      @(posedge ref_clk);
      chain_rst <= 1'b1;
      @(posedge ref_clk);
      chain_rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk({15'h0000, sync_flood_q}, 16'h0000, "flood ended");
      chk({15'h0000, chain_fail_q}, 16'h0000, "chain fail cleared");
      done_t("overflow flood");
      close_out();
   end
endmodule : tb_top

`default_nettype wire
